// ---- pin_function_mux_params.svh ----
`ifndef PIN_FUNCTION_MUX_PARAMS_SVH
`define PIN_FUNCTION_MUX_PARAMS_SVH

`define PFM_PIN_COUNT         30
`define PFM_GROUP_COUNT       8
`define PFM_UNGROUPED         4'h8

`define PFM_OFS_GROUP_ROUTE   32'h0020_4000
`define PFM_OFS_SOURCE_LOW    32'h0020_4004
`define PFM_OFS_SOURCE_SECOND 32'h0020_4010
`define PFM_OFS_SOURCE_THIRD  32'h0020_4008
`define PFM_OFS_SOURCE_HIGH   32'h0020_400C
`define PFM_OFS_CTS_PICK      32'h0020_4018
`define PFM_OFS_COUNTER_PICK  32'h0020_4020
`define PFM_OFS_LEVEL_DATA    32'h0020_4040
`define PFM_OFS_DRIVE_ENABLE  32'h0020_404C
`define PFM_OFS_READ_INVERT   32'h0020_4050

`define PFM_MASK_GROUP_ROUTE  32'h7777_7777
`define PFM_MASK_SOURCE       32'hFFFF_FFFF
`define PFM_MASK_SOURCE_HIGH  32'h00FF_FFFF
`define PFM_MASK_CTS_PICK     32'h0000_1F00
`define PFM_MASK_COUNTER_PICK 32'h0000_0003
`define PFM_MASK_PINS         32'h3FFF_FFFF

`define PFM_RST_GROUP_ROUTE   32'h0000_0000
`define PFM_RST_SOURCE        32'h0000_0000
`define PFM_RST_CTS_PICK      32'h0000_0000
`define PFM_RST_COUNTER_PICK  32'h0000_0000
`define PFM_RST_PINS          32'h0000_0000

`define PFM_ROUTE_FIELD_W     4
`define PFM_SOURCE_FIELD_W    4
`define PFM_CTS_LSB           8
`define PFM_CTS_W             5
`define PFM_COUNTER0_BIT      0
`define PFM_COUNTER1_BIT      1

`endif

// ---- pin_function_mux_pkg.sv ----
package pin_function_mux_pkg;

  typedef enum logic [2:0] {
    ROUTE_DIRECT = 3'h0,
    ROUTE_SPI    = 3'h1,
    ROUTE_TIMER  = 3'h2,
    ROUTE_UART2  = 3'h3,
    ROUTE_MOUSE  = 3'h4,
    ROUTE_CARD   = 3'h5
  } route_code_t;

  typedef enum logic [3:0] {
    SOURCE_CPU          = 4'h0,
    SOURCE_PULSE_ONE    = 4'h1,
    SOURCE_PULSE_TWO    = 4'h2,
    SOURCE_PULSE_THREE  = 4'h3,
    SOURCE_PULSE_FOUR   = 4'h4,
    SOURCE_XTAL16M      = 4'h5,
    SOURCE_RTS          = 4'h6,
    SOURCE_INFRARED_32K = 4'h7,
    SOURCE_XTAL32K      = 4'h8
  } source_code_t;

endpackage

// ---- pin_function_mux.sv ----
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "pin_function_mux_params.svh"

//Contract
// - Thirty shared pins carry every peripheral signal.
// - Pins 26-29 group: SPI, timer, mouse, card.
// - Pins 24-25 group: timer, uart2, mouse Z.
// - Bits 10:8 route pins 20-23 likewise.
// - Bits 14:12 route pins 18-19 likewise.
// - Bits 18:16 route pins 14-17 likewise.
// - Bits 22:20 route pins 12-13 likewise.
// - Bits 26:24 route pins 0-3 likewise.
// - Bits 30:28 route pins 4-5 likewise.
// - Zero group code uses per-pin source; resets zero.
// - Per-pin source codes pick CPU, PWM, clocks, RTS.
// - Eight 4-bit source fields per register; six in the high one.
// - Data reads pin levels, writes drive enabled pins.
// - Enable bit set makes pin output; resets inputs.
// - Invert bit flips software read level.
// - Bits 12:8 choose CTS pin, reset pin 0.
// - Counter 0 on 0x groups or 1x groups.
// - Counter 1 on 3x groups or 2x groups.
module pin_function_mux (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Package pins.
  input  wire logic [29:0] pin_in,
  output logic      [29:0] pin_out,
  output logic      [29:0] pin_oe_n,
  // Per-pin output sources.
  input  wire logic [3:0]  pulse_width_out,
  input  wire logic        crystal_16m_clock,
  input  wire logic        serial_rts_out,
  input  wire logic        infrared_32k_out,
  input  wire logic        crystal_32k_clock,
  // First serial port clear-to-send, active low.
  output logic             serial_cts_n,
  // SPI, four-pin groups.
  input  wire logic [3:0]  spi_out,
  input  wire logic [3:0]  spi_drive,
  output logic      [3:0]  spi_in,
  // Smart card, four-pin groups.
  input  wire logic [3:0]  card_out,
  input  wire logic [3:0]  card_drive,
  output logic      [3:0]  card_in,
  // Mouse inputs.
  output logic      [3:0]  mouse_xy_in,
  output logic      [1:0]  mouse_z_in,
  // Second serial port, two-pin groups.
  input  wire logic [1:0]  uart2_out,
  input  wire logic [1:0]  uart2_drive,
  output logic      [1:0]  uart2_in,
  // Counters: slots 0-3 four-pin group, 4-5 two-pin group.
  input  wire logic [5:0]  counter0_out,
  input  wire logic [5:0]  counter0_drive,
  output logic      [5:0]  counter0_in,
  input  wire logic [5:0]  counter1_out,
  input  wire logic [5:0]  counter1_drive,
  output logic      [5:0]  counter1_in
);

  logic [31:0]  pin_group_route;
  logic [31:0]  pin_source_select_low;
  logic [31:0]  pin_source_select_second;
  logic [31:0]  pin_source_select_third;
  logic [31:0]  pin_source_select_high;
  logic [31:0]  serial_cts_pin_pick;
  logic [31:0]  counter_group_pick;
  logic [29:0]  pin_level_bits;
  logic [29:0]  pin_drive_enable;
  logic [29:0]  pin_read_invert;
  logic [29:0]  sync_a;
  logic [29:0]  sync_b;
  logic [29:0]  sync_c;
  logic [29:0]  pin_level;
  logic [127:0] source_all;
  logic [29:0]  next_pin_out;
  logic [29:0]  next_drive;
  logic [31:0]  read_value;
  logic         read_hit;
  logic         write_strobe;
  logic [3:0]   grp;
  logic [1:0]   pos;
  logic [2:0]   slot;
  logic [2:0]   code;
  logic [3:0]   source;
  logic         four_pin;
  logic         counter_id;
  logic         counter_here;
  logic [4:0]   cts_pick;

  // Group index of a pin; pins 6 to 11 belong to no group.
  function automatic logic [3:0] grp_of(input int n);
    if (n >= 26)
      return 4'h0;
    else if (n >= 24)
      return 4'h1;
    else if (n >= 20)
      return 4'h2;
    else if (n >= 18)
      return 4'h3;
    else if (n >= 14)
      return 4'h4;
    else if (n >= 12)
      return 4'h5;
    else if (n <= 3)
      return 4'h6;
    else if (n <= 5)
      return 4'h7;
    else
      return `PFM_UNGROUPED;
  endfunction

  function automatic logic [1:0] pos_of(input int n);
    int base;
    base = 0;
    if (n >= 26)
      base = 26;
    else if (n >= 24)
      base = 24;
    else if (n >= 20)
      base = 20;
    else if (n >= 18)
      base = 18;
    else if (n >= 14)
      base = 14;
    else if (n >= 12)
      base = 12;
    else if (n >= 4)
      base = 4;
    return 2'(n - base);
  endfunction

  assign pready       = penable;
  assign write_strobe = psel && penable && pwrite && read_hit;

  // Three stages; a level counts once the last two agree.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_c    <= '0;
      pin_level <= '0;
    end
    else
    begin
      sync_a    <= pin_in;
      sync_b    <= sync_a;
      sync_c    <= sync_b;
      pin_level <= (sync_b & sync_c) | (pin_level & (sync_b ^ sync_c));
    end
  end

  always_comb
  begin
    read_hit   = 1'b1;
    read_value = 32'h0000_0000;
    unique case (paddr)
      `PFM_OFS_GROUP_ROUTE:   read_value = pin_group_route;
      `PFM_OFS_SOURCE_LOW:    read_value = pin_source_select_low;
      `PFM_OFS_SOURCE_SECOND: read_value = pin_source_select_second;
      `PFM_OFS_SOURCE_THIRD:  read_value = pin_source_select_third;
      `PFM_OFS_SOURCE_HIGH:   read_value = pin_source_select_high;
      `PFM_OFS_CTS_PICK:      read_value = serial_cts_pin_pick;
      `PFM_OFS_COUNTER_PICK:  read_value = counter_group_pick;
      `PFM_OFS_LEVEL_DATA:
        read_value = {2'b00, pin_level ^ pin_read_invert};
      `PFM_OFS_DRIVE_ENABLE:  read_value = {2'b00, pin_drive_enable};
      `PFM_OFS_READ_INVERT:   read_value = {2'b00, pin_read_invert};
      default:                read_hit = 1'b0;
    endcase
  end

  // Read data is caught in the setup cycle, so the access ends at once.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : read_value;
      pslverr <= !read_hit;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pin_group_route          <= `PFM_RST_GROUP_ROUTE;
      pin_source_select_low    <= `PFM_RST_SOURCE;
      pin_source_select_second <= `PFM_RST_SOURCE;
      pin_source_select_third  <= `PFM_RST_SOURCE;
      pin_source_select_high   <= `PFM_RST_SOURCE;
      serial_cts_pin_pick      <= `PFM_RST_CTS_PICK;
      counter_group_pick       <= `PFM_RST_COUNTER_PICK;
      pin_level_bits           <= 30'(`PFM_RST_PINS);
      pin_drive_enable         <= 30'(`PFM_RST_PINS);
      pin_read_invert          <= 30'(`PFM_RST_PINS);
    end
    else if (write_strobe)
    begin
      unique case (paddr)
        `PFM_OFS_GROUP_ROUTE:
          pin_group_route <= pwdata & `PFM_MASK_GROUP_ROUTE;
        `PFM_OFS_SOURCE_LOW:
          pin_source_select_low <= pwdata & `PFM_MASK_SOURCE;
        `PFM_OFS_SOURCE_SECOND:
          pin_source_select_second <= pwdata & `PFM_MASK_SOURCE;
        `PFM_OFS_SOURCE_THIRD:
          pin_source_select_third <= pwdata & `PFM_MASK_SOURCE;
        `PFM_OFS_SOURCE_HIGH:
          pin_source_select_high <= pwdata & `PFM_MASK_SOURCE_HIGH;
        `PFM_OFS_CTS_PICK:
          serial_cts_pin_pick <= pwdata & `PFM_MASK_CTS_PICK;
        `PFM_OFS_COUNTER_PICK:
          counter_group_pick <= pwdata & `PFM_MASK_COUNTER_PICK;
        `PFM_OFS_LEVEL_DATA:
          pin_level_bits <= 30'(pwdata & `PFM_MASK_PINS);
        `PFM_OFS_DRIVE_ENABLE:
          pin_drive_enable <= 30'(pwdata & `PFM_MASK_PINS);
        `PFM_OFS_READ_INVERT:
          pin_read_invert <= 30'(pwdata & `PFM_MASK_PINS);
        default:
          pin_group_route <= pin_group_route;
      endcase
    end
  end

  // Pin n takes its source field from bit 4*n of the packed registers.
  assign source_all = {pin_source_select_high, pin_source_select_third,
                       pin_source_select_second, pin_source_select_low};

  // Where two groups share one function, the later pin in the loop wins
  // the peripheral input; outputs go to every selected group, timer groups only where the counter pick names them.
  always_comb
  begin
    grp          = 4'h0;
    pos          = 2'h0;
    slot         = 3'h0;
    code         = 3'h0;
    source       = 4'h0;
    four_pin     = 1'b0;
    counter_id   = 1'b0;
    counter_here = 1'b0;
    next_pin_out = '0;
    next_drive   = '0;
    spi_in       = '0;
    card_in      = '0;
    mouse_xy_in  = '0;
    mouse_z_in   = '0;
    uart2_in     = '0;
    counter0_in  = '0;
    counter1_in  = '0;
    for (int n = 0; n < `PFM_PIN_COUNT; n++)
    begin
      grp      = grp_of(n);
      pos      = pos_of(n);
      four_pin = !grp[0];
      slot     = four_pin ? {1'b0, pos} : {1'b1, 1'b0, pos[0]};
      source   = source_all[4*n +: 4];
      code     = (grp == `PFM_UNGROUPED) ? 3'h0 :
                 pin_group_route[4*grp[2:0] +: 3];
      counter_id   = grp[2];
      counter_here = counter_id ?
        (counter_group_pick[`PFM_COUNTER1_BIT] == (grp[2:1] == 2'b10)) :
        (counter_group_pick[`PFM_COUNTER0_BIT] == (grp[2:1] == 2'b01));
      next_pin_out[n] = pin_level_bits[n];
      next_drive[n]   = pin_drive_enable[n];
      if (code == pin_function_mux_pkg::ROUTE_DIRECT)
      begin
        unique case (source)
          pin_function_mux_pkg::SOURCE_PULSE_ONE,
          pin_function_mux_pkg::SOURCE_PULSE_TWO,
          pin_function_mux_pkg::SOURCE_PULSE_THREE,
          pin_function_mux_pkg::SOURCE_PULSE_FOUR:
          begin
            next_pin_out[n] = pulse_width_out[source[1:0] - 2'd1];
            next_drive[n]   = 1'b1;
          end
          pin_function_mux_pkg::SOURCE_XTAL16M:
          begin
            next_pin_out[n] = crystal_16m_clock;
            next_drive[n]   = 1'b1;
          end
          pin_function_mux_pkg::SOURCE_RTS:
          begin
            next_pin_out[n] = serial_rts_out;
            next_drive[n]   = 1'b1;
          end
          pin_function_mux_pkg::SOURCE_INFRARED_32K:
          begin
            next_pin_out[n] = infrared_32k_out;
            next_drive[n]   = 1'b1;
          end
          pin_function_mux_pkg::SOURCE_XTAL32K:
          begin
            next_pin_out[n] = crystal_32k_clock;
            next_drive[n]   = 1'b1;
          end
          default:
            next_drive[n] = pin_drive_enable[n];
        endcase
      end
      else if (code == pin_function_mux_pkg::ROUTE_SPI && four_pin)
      begin
        next_pin_out[n] = spi_out[pos];
        next_drive[n]   = spi_drive[pos];
        spi_in[pos]     = pin_level[n];
      end
      else if (code == pin_function_mux_pkg::ROUTE_CARD && four_pin)
      begin
        next_pin_out[n] = card_out[pos];
        next_drive[n]   = card_drive[pos];
        card_in[pos]    = pin_level[n];
      end
      else if (code == pin_function_mux_pkg::ROUTE_UART2 && !four_pin)
      begin
        next_pin_out[n]  = uart2_out[pos[0]];
        next_drive[n]    = uart2_drive[pos[0]];
        uart2_in[pos[0]] = pin_level[n];
      end
      else if (code == pin_function_mux_pkg::ROUTE_MOUSE)
      begin
        next_drive[n] = 1'b0;
        if (four_pin)
          mouse_xy_in[pos] = pin_level[n];
        else
          mouse_z_in[pos[0]] = pin_level[n];
      end
      else if (code == pin_function_mux_pkg::ROUTE_TIMER && counter_here)
      begin
        if (counter_id)
        begin
          next_pin_out[n]   = counter1_out[slot];
          next_drive[n]     = counter1_drive[slot];
          counter1_in[slot] = pin_level[n];
        end
        else
        begin
          next_pin_out[n]   = counter0_out[slot];
          next_drive[n]     = counter0_drive[slot];
          counter0_in[slot] = pin_level[n];
        end
      end
    end
  end

  // Registered pins keep glitches of the mux off the pads.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end
    else
    begin
      pin_out  <= next_pin_out;
      pin_oe_n <= ~next_drive;
    end
  end

  // An out-of-range pick reads as deasserted rather than a random pin.
  assign cts_pick = serial_cts_pin_pick[`PFM_CTS_LSB +: `PFM_CTS_W];

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      serial_cts_n <= 1'b1;
    else if (cts_pick < 5'(`PFM_PIN_COUNT))
      serial_cts_n <= pin_level[cts_pick];
    else
      serial_cts_n <= 1'b1;
  end

endmodule // pin_function_mux

// ---- pin_function_mux_props.sv ----
`timescale 1ns/10ps
`include "pin_function_mux_params.svh"
module pin_function_mux_props (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and functions.
  input wire logic [29:0] pin_out,
  input wire logic [29:0] pin_oe_n,
  input wire logic [3:0]  pulse_width_out,
  input wire logic        serial_cts_n,
  input wire logic [3:0]  spi_in
);
  // Bus-snooped copies, so output checks need no access to the body.
  logic [31:0] grp;
  logic [31:0] src;
  logic [31:0] oe;
  logic        wr_ok;
  logic        mapped;
  logic        any_spi;
  assign wr_ok = psel && penable && pwrite && pready;
  assign mapped = paddr inside {`PFM_OFS_GROUP_ROUTE, `PFM_OFS_SOURCE_LOW,
    `PFM_OFS_SOURCE_SECOND, `PFM_OFS_SOURCE_THIRD, `PFM_OFS_SOURCE_HIGH,
    `PFM_OFS_CTS_PICK, `PFM_OFS_COUNTER_PICK, `PFM_OFS_LEVEL_DATA,
    `PFM_OFS_DRIVE_ENABLE, `PFM_OFS_READ_INVERT};
  assign any_spi = (grp[2:0] == 3'h1) || (grp[10:8] == 3'h1) ||
                   (grp[18:16] == 3'h1) || (grp[26:24] == 3'h1);
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      grp <= 32'h0000_0000;
      src <= 32'h0000_0000;
      oe  <= 32'h0000_0000;
    end
    else if (wr_ok && paddr == `PFM_OFS_GROUP_ROUTE)
      grp <= pwdata & `PFM_MASK_GROUP_ROUTE;
    else if (wr_ok && paddr == `PFM_OFS_SOURCE_LOW)
      src <= pwdata;
    else if (wr_ok && paddr == `PFM_OFS_DRIVE_ENABLE)
      oe <= pwdata & `PFM_MASK_PINS;
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_READY: assert property (s_setup ##1 s_access |-> pready)
    else $error("access phase without ready");
  AST_SLVERR: assert property (s_setup |=> pslverr == !$past(mapped))
    else $error("slave error does not match the address map");
  AST_WRZERO: assert property (s_setup and pwrite |=> prdata == 32'h0)
    else $error("read data not zero on a write");
  AST_SPI_IDLE: assert property (!any_spi |-> spi_in == 4'h0)
    else $error("spi input live with no spi group");
  AST_MOUSE_HIZ: assert property ($past(grp[26:24]) == 3'h4 |->
    pin_oe_n[3:0] == 4'hF) else $error("mouse group pins driven");
  AST_SRC_DRIVE: assert property ($past(src[27:24]) inside {[4'h1:4'h8]}
    |-> !pin_oe_n[6]) else $error("source pin not driven");
  AST_SRC_PWM: assert property ($past(src[27:24]) == 4'h1 |->
    pin_out[6] == $past(pulse_width_out[0])) else $error("pwm not on pin");
  AST_GPIO_OE: assert property ($past(src[27:24]) == 4'h0 |->
    pin_oe_n[6] == !$past(oe[6])) else $error("enable bit not on pin");
  AST_OE_RESET: assert property (disable iff (1'b0) !reset_n |=>
    pin_oe_n == 30'h3FFF_FFFF) else $error("pins driven after reset");
  AST_CTS_RESET: assert property (disable iff (1'b0) !reset_n |=>
    serial_cts_n) else $error("clear-to-send low after reset");
endmodule // pin_function_mux_props

bind pin_function_mux pin_function_mux_props i_pin_function_mux_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pulse_width_out(pulse_width_out),
  .serial_cts_n(serial_cts_n), .spi_in(spi_in));

// ---- pin_pad_model.sv ----
`timescale 1ns/10ps
module pin_pad_model (
  // Pad side of the mux.
  input  wire logic [29:0] pin_out,
  input  wire logic [29:0] pin_oe_n,
  // Level the board holds on pads that nobody drives.
  input  wire logic [29:0] board_level,
  // Level seen back at the pad inputs.
  output logic      [29:0] pin_in
);
  // A driven pad reads back its own level; there is no keeper otherwise.
  assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
endmodule // pin_pad_model

// ---- pin_function_mux_test.sv ----
`timescale 1ns/10ps
`include "pin_function_mux_params.svh"
`define CHK(n, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("unexpected %s expected %h seen %h", n, e, g); \
    end \
  end
module pin_function_mux_test;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0000_0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [29:0] ext     = 30'h1234_5678;
  logic [7:0]  srcv    = 8'h00;
  logic [3:0]  drv     = 4'hF;
  logic [3:0]  spi_o   = 4'hA;
  logic [3:0]  card_o  = 4'h6;
  logic [1:0]  u2_o    = 2'h2;
  logic [5:0]  c0_o    = 6'h1A;
  logic [5:0]  c1_o    = 6'h25;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, cts_n;
  logic [29:0] pin_in, pin_out, pin_oe_n;
  logic [3:0]  spi_in, card_in, xy_in;
  logic [1:0]  z_in, u2_in;
  logic [5:0]  c0_in, c1_in;
  int          failures = 0;
  int          comparisons = 0;
  localparam logic [31:0] ADR [10] = '{`PFM_OFS_GROUP_ROUTE,
    `PFM_OFS_SOURCE_LOW, `PFM_OFS_SOURCE_SECOND, `PFM_OFS_SOURCE_THIRD,
    `PFM_OFS_SOURCE_HIGH, `PFM_OFS_CTS_PICK, `PFM_OFS_COUNTER_PICK,
    `PFM_OFS_LEVEL_DATA, `PFM_OFS_DRIVE_ENABLE, `PFM_OFS_READ_INVERT};
  localparam logic [31:0] MSK [10] = '{`PFM_MASK_GROUP_ROUTE,
    `PFM_MASK_SOURCE, `PFM_MASK_SOURCE, `PFM_MASK_SOURCE,
    `PFM_MASK_SOURCE_HIGH, `PFM_MASK_CTS_PICK, `PFM_MASK_COUNTER_PICK,
    `PFM_MASK_PINS, `PFM_MASK_PINS, `PFM_MASK_PINS};
  localparam int LSB [8] = '{0, 8, 16, 24, 4, 12, 20, 28};
  localparam int PIN [8] = '{26, 20, 14, 0, 24, 18, 12, 4};
  localparam logic [2:0] C4 [6] = '{3'h1, 3'h5, 3'h4, 3'h3, 3'h2, 3'h2};
  localparam logic [2:0] C2 [6] = '{3'h3, 3'h4, 3'h1, 3'h5, 3'h2, 3'h2};

  pin_function_mux i_pin_function_mux (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pulse_width_out(srcv[3:0]), .crystal_16m_clock(srcv[4]),
    .serial_rts_out(srcv[5]), .infrared_32k_out(srcv[6]),
    .crystal_32k_clock(srcv[7]), .serial_cts_n(cts_n),
    .spi_out(spi_o), .spi_drive(drv), .spi_in(spi_in),
    .card_out(card_o), .card_drive(drv), .card_in(card_in),
    .mouse_xy_in(xy_in), .mouse_z_in(z_in), .uart2_out(u2_o),
    .uart2_drive(drv[1:0]), .uart2_in(u2_in), .counter0_out(c0_o),
    .counter0_drive({drv[1:0], drv}), .counter0_in(c0_in),
    .counter1_out(c1_o), .counter1_drive({drv[1:0], drv}),
    .counter1_in(c1_in));
  pin_pad_model i_pin_pad_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .board_level(ext), .pin_in(pin_in));

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read data", e, rd)
    `CHK("slave error", 1'b0, err)
  endtask

  // Pin inputs pass a synchroniser and filter before they are seen.
  task automatic settle;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic close_out;
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    logic [3:0] eo, ev, m;
    logic [5:0] e0, e1;
    logic [2:0] c;
    logic [1:0] pk;
    int         p;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++)
      chk_rd(ADR[i], (i == 7) ? {2'b00, ext} : 32'h0000_0000);
    apb(1'b0, 32'h0020_4030, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    for (int i = 0; i < 10; i++)
      if (i != 7)
      begin
        apb(1'b1, ADR[i], 32'hFFFF_FFFF);
        chk_rd(ADR[i], MSK[i]);
      end
    apb(1'b1, `PFM_OFS_SOURCE_LOW, 32'h0000_0000);
    chk_rd(`PFM_OFS_SOURCE_SECOND, 32'hFFFF_FFFF);
    for (int i = 0; i < 10; i++)
      apb(1'b1, ADR[i], 32'h0000_0000);
    apb(1'b1, `PFM_OFS_DRIVE_ENABLE, 32'h0000_0140);
    apb(1'b1, `PFM_OFS_LEVEL_DATA, 32'h0000_0040);
    settle;
    `CHK("pin 6 enable", 1'b0, pin_oe_n[6])
    `CHK("pin 6 level", 1'b1, pin_out[6])
    chk_rd(ADR[7], {2'b00, (ext & ~30'h140) | 30'h40});
    apb(1'b1, `PFM_OFS_READ_INVERT, `PFM_MASK_PINS);
    chk_rd(ADR[7], {2'b00, ~((ext & ~30'h140) | 30'h40)});
    apb(1'b1, `PFM_OFS_READ_INVERT, 32'h0000_0000);
    apb(1'b1, `PFM_OFS_DRIVE_ENABLE, 32'h0000_0000);
    for (int s = 1; s < 10; s++)
    begin
      srcv <= 8'h01 << (s - 1);
      apb(1'b1, `PFM_OFS_SOURCE_LOW, s << 24);
      settle;
      `CHK("source enable", s > 8, pin_oe_n[6])
      if (s < 9)
      begin
        `CHK("source high", 1'b1, pin_out[6])
        srcv <= ~(8'h01 << (s - 1));
        settle;
        `CHK("source low", 1'b0, pin_out[6])
      end
    end
    apb(1'b1, `PFM_OFS_SOURCE_LOW, 32'h0000_0000);
    for (int g = 0; g < 8; g++)
      for (int k = 0; k < 6; k++)
      begin
        c = (g < 4) ? C4[k] : C2[k];
        pk = (k == 5) ? 2'b11 : 2'b00;
        p = PIN[g];
        m = (g < 4) ? 4'hF : 4'h3;
        apb(1'b1, `PFM_OFS_COUNTER_PICK, {30'h0, pk});
        apb(1'b1, `PFM_OFS_GROUP_ROUTE, {29'h0, c} << LSB[g]);
        settle;
        ev = 4'h0;
        if (g < 4 && c == 3'h1)
          ev = spi_o;
        if (g < 4 && c == 3'h5)
          ev = card_o;
        if (g >= 4 && c == 3'h3)
          ev = {2'b00, u2_o};
        if (c == 3'h2 && g % 4 == pk[0])
          ev = (g < 4) ? c0_o[3:0] : {2'b00, c0_o[5:4]};
        if (c == 3'h2 && g % 4 == 3 - pk[0])
          ev = (g < 4) ? c1_o[3:0] : {2'b00, c1_o[5:4]};
        // Every peripheral pattern is non-zero, so zero means not driven.
        eo = (ev == 4'h0) ? 4'hF : 4'h0;
        `CHK("group enable", eo & m, pin_oe_n[p +: 4] & m)
        `CHK("group level", ev & m, pin_out[p +: 4] & m & ~eo)
        // Driven pins read back, so each routed input mirrors its output.
        `CHK("spi in", (c == 3'h1) ? ev : 4'h0, spi_in)
        `CHK("card in", (c == 3'h5) ? ev : 4'h0, card_in)
        `CHK("uart2 in", (c == 3'h3) ? ev[1:0] : 2'h0, u2_in)
        e0 = (g < 4) ? 6'h0F : 6'h30;
        e1 = (c == 3'h2 && g % 4 == 3 - pk[0]) ? c1_o & e0 : 6'h00;
        e0 = (c == 3'h2 && g % 4 == pk[0]) ? c0_o & e0 : 6'h00;
        `CHK("counter0 in", e0, c0_in)
        `CHK("counter1 in", e1, c1_in)
        if (c == 3'h4 && g < 4)
          `CHK("mouse xy", ext[p +: 4], xy_in)
        if (c == 3'h4 && g >= 4)
          `CHK("mouse z", ext[p +: 2], z_in)
      end
    apb(1'b1, `PFM_OFS_GROUP_ROUTE, 32'h0000_0000);
    apb(1'b1, `PFM_OFS_CTS_PICK, 32'h0000_1D00);
    for (int v = 0; v < 2; v++)
    begin
      ext[29] <= v[0];
      settle;
      `CHK("clear to send", v[0], cts_n)
    end
    close_out;
  end

  initial
  begin
    #100000;
    failures++;
    close_out;
  end
endmodule // pin_function_mux_test
